// *** hw/tws_pkg.sv ***
package tws_pkg;

  // fixed upper bits of the slave address; the low bit comes from the select pin
  localparam logic [5:0] ADDR_UPPER = 6'h26;
  localparam int ADDR_WIDTH = 7;
  localparam int DATA_WIDTH = 8;
  localparam int REG_COUNT = 256;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;

  // protocol phases of the slave
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEV_ADDR,
    ST_REG_ADDR,
    ST_WR_DATA,
    ST_RD_DATA,
    ST_IGNORE
  } tws_state_type;

  // filtered line events from the sampler
  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
  } tws_line_type;

  // one register write toward the register file
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } tws_write_type;

endpackage : tws_pkg

// *** hw/tws_line_sampler.sv ***
`timescale 1ns/1ps

// samples both bus lines through three flops and reports edges and conditions
module tws_line_sampler
(
  input wire logic clk,
  input wire logic srst,
  input wire logic scl_in,
  input wire logic sda_in,
  output tws_pkg::tws_line_type line
);

  logic [2:0] scl_sync_reg;
  logic [2:0] sda_sync_reg;
  logic scl_reg;
  logic sda_reg;
  logic scl_next;
  logic sda_next;

  ////////////////////////////////////////////////////////////////////////////
  // three-stage synchronisers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
    end
    else
    begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
    end
  end

  // a level change counts once stages two and three agree
  always_comb
  begin
    scl_next = scl_reg;
    sda_next = sda_reg;
    if (scl_sync_reg[1] == scl_sync_reg[2])
    begin
      scl_next = scl_sync_reg[2];
    end
    if (sda_sync_reg[1] == sda_sync_reg[2])
    begin
      sda_next = sda_sync_reg[2];
    end
  end

  // filtered levels, idle high like the pulled-up bus
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
    end
    else
    begin
      scl_reg <= scl_next;
      sda_reg <= sda_next;
    end
  end

  // sda moving while scl stays high marks start or stop
  assign line.scl_rise = scl_next & ~scl_reg;
  assign line.scl_fall = ~scl_next & scl_reg;
  assign line.start = scl_reg & scl_next & sda_reg & ~sda_next; // RL2
  assign line.stop = scl_reg & scl_next & ~sda_reg & sda_next; // RL3
  assign line.sda = sda_next;

endmodule : tws_line_sampler

// *** hw/tws_slave.sv ***
`timescale 1ns/1ps

// Behaviour
// RL1 - data changes only while clock low
// RL2 - falling data with clock high starts
// RL3 - rising data with clock high stops, idles
// RL4 - first byte: seven address bits, direction
// RL5 - acknowledge own address on ninth pulse
// RL6 - address from fixed bits plus select pin
// RL7 - bytes travel most significant bit first
// RL8 - no acknowledge leaves data line released
// RL9 - master no-acknowledge ends read, release line
// RL10 - second write byte is base address
// RL11 - write data increments register address
// RL12 - read from base, increment per byte
// RL13 - master sets base before reading
// RL14 - repeated start begins new address phase
// RL15 - data line only pulled low, never high
// RL16 - start or stop mid-byte abandons byte
module tws_slave
#(
  parameter int REGS = tws_pkg::REG_COUNT
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic slave_addr_select_pins,
  output logic sda_out,
  output logic sda_oe,
  output logic busy,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic wr_strobe
);

  tws_pkg::tws_line_type line;
  tws_pkg::tws_state_type state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic [7:0] base_addr_reg;
  logic ack_reg;
  logic drive_low_reg;
  logic sel_reg;
  logic [7:0] regs [0:REGS-1];
  logic [6:0] own_addr;
  logic [7:0] byte_in;
  logic byte_done;
  logic ack_bit_end;

  ////////////////////////////////////////////////////////////////////////////
  // line conditioning
  tws_line_sampler u_sampler
  (
    .clk(clk),
    .srst(srst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .line(line)
  );

  // select pin is sampled in the clock domain before use
  logic [2:0] sel_sync_reg;
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sel_sync_reg <= 3'h0;
      sel_reg <= 1'b0;
    end
    else
    begin
      sel_sync_reg <= {sel_sync_reg[1:0], slave_addr_select_pins};
      if (sel_sync_reg[1] == sel_sync_reg[2])
      begin
        sel_reg <= sel_sync_reg[2];
      end
    end
  end

  // own address: fixed upper bits, pin in the low bit
  assign own_addr = {tws_pkg::ADDR_UPPER, sel_reg}; // RL6

  // eighth bit completes on its rising clock edge
  assign byte_in = {shift_reg[6:0], line.sda}; // RL7
  assign byte_done = line.scl_rise && (bit_cnt_reg == tws_pkg::BIT_LAST);
  assign ack_bit_end = line.scl_fall && (bit_cnt_reg == tws_pkg::BIT_ACK);

  ////////////////////////////////////////////////////////////////////////////
  // bit counter: 0..7 data bits, 8 acknowledge slot
  always_ff @(posedge clk)
  begin
    if (srst || line.stop)
    begin
      bit_cnt_reg <= 4'h0; // RL16
    end
    // one below zero: the fall that closes the start brings it to bit 0
    else if (line.start)
    begin
      bit_cnt_reg <= 4'hf; // RL16 RL5
    end
    else if (ack_bit_end)
    begin
      bit_cnt_reg <= 4'h0;
    end
    else if (line.scl_fall && bit_cnt_reg != tws_pkg::BIT_ACK && byte_done == 1'b0)
    begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end

  // incoming shifter samples on rising clock
  always_ff @(posedge clk)
  begin
    if (srst || line.start || line.stop)
    begin
      shift_reg <= 8'h00; // RL16
    end
    else if (line.scl_rise && bit_cnt_reg != tws_pkg::BIT_ACK)
    begin
      shift_reg <= byte_in; // RL7
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // protocol state machine
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_reg <= tws_pkg::ST_IDLE;
      ack_reg <= 1'b0;
    end
    else if (line.stop)
    begin
      state_reg <= tws_pkg::ST_IDLE; // RL3
      ack_reg <= 1'b0;
    end
    else if (line.start)
    begin
      state_reg <= tws_pkg::ST_DEV_ADDR; // RL2 RL14
      ack_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        tws_pkg::ST_IDLE:
        begin
          ack_reg <= 1'b0;
        end
        tws_pkg::ST_DEV_ADDR:
        begin
          if (byte_done)
          begin
            ack_reg <= (byte_in[7:1] == own_addr); // RL4 RL5
          end
          else if (ack_bit_end)
          begin
            if (!ack_reg)
            begin
              state_reg <= tws_pkg::ST_IGNORE; // RL8
            end
            else if (shift_reg[0])
            begin
              state_reg <= tws_pkg::ST_RD_DATA; // RL4 RL13
            end
            else
            begin
              state_reg <= tws_pkg::ST_REG_ADDR;
            end
          end
        end
        tws_pkg::ST_REG_ADDR:
        begin
          if (byte_done)
          begin
            ack_reg <= 1'b1;
          end
          else if (ack_bit_end)
          begin
            state_reg <= tws_pkg::ST_WR_DATA;
          end
        end
        tws_pkg::ST_WR_DATA:
        begin
          if (byte_done)
          begin
            ack_reg <= 1'b1;
          end
        end
        tws_pkg::ST_RD_DATA:
        begin
          // master acknowledge sampled on the ninth rising edge
          if (line.scl_rise && bit_cnt_reg == tws_pkg::BIT_ACK && line.sda)
          begin
            state_reg <= tws_pkg::ST_IGNORE; // RL9
          end
          ack_reg <= 1'b0;
        end
        tws_pkg::ST_IGNORE:
        begin
          ack_reg <= 1'b0;
        end
        default:
        begin
          state_reg <= tws_pkg::ST_IDLE;
          ack_reg <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // base address: stored from the address byte, stepped per data byte
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      base_addr_reg <= tws_pkg::REG_RESET;
    end
    else if (byte_done && state_reg == tws_pkg::ST_REG_ADDR && !line.start && !line.stop)
    begin
      base_addr_reg <= byte_in; // RL10
    end
    else if (ack_bit_end && state_reg == tws_pkg::ST_WR_DATA)
    begin
      base_addr_reg <= base_addr_reg + 8'h01; // RL11
    end
    else if (line.scl_rise && bit_cnt_reg == tws_pkg::BIT_ACK
             && state_reg == tws_pkg::ST_RD_DATA)
    begin
      base_addr_reg <= base_addr_reg + 8'h01; // RL12
    end
  end

  // register file and write port
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wr_strobe <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end
    else
    begin
      wr_strobe <= 1'b0;
      if (byte_done && state_reg == tws_pkg::ST_WR_DATA && !line.start && !line.stop)
      begin
        wr_strobe <= 1'b1;
        wr_addr <= base_addr_reg; // RL11
        wr_data <= byte_in;
      end
    end
  end

  // storage array, written with the same data as the strobe
  always_ff @(posedge clk)
  begin
    if (byte_done && state_reg == tws_pkg::ST_WR_DATA && !line.start && !line.stop)
    begin
      regs[base_addr_reg] <= byte_in;
    end
  end

  // transmit byte loaded when the read phase opens or after each ack slot
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      tx_reg <= 8'h00;
    end
    else if (ack_bit_end)
    begin
      tx_reg <= regs[(state_reg == tws_pkg::ST_DEV_ADDR) ? base_addr_reg : base_addr_reg]; // RL12
    end
    else if (line.scl_fall && state_reg == tws_pkg::ST_RD_DATA
             && bit_cnt_reg < tws_pkg::BIT_LAST)
    begin
      tx_reg <= {tx_reg[6:0], 1'b0}; // RL7
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data line drive: only ever low, updated just after scl falls
  always_ff @(posedge clk)
  begin
    if (srst || line.start || line.stop)
    begin
      drive_low_reg <= 1'b0; // RL16
    end
    else if (line.scl_fall)
    begin
      if (bit_cnt_reg == tws_pkg::BIT_LAST)
      begin
        drive_low_reg <= ack_reg; // RL5 RL8 RL1
      end
      else if (ack_bit_end && state_reg == tws_pkg::ST_DEV_ADDR && ack_reg && shift_reg[0])
      begin
        drive_low_reg <= ~regs[base_addr_reg][7]; // RL12
      end
      else if (ack_bit_end && state_reg == tws_pkg::ST_RD_DATA)
      begin
        drive_low_reg <= ~regs[base_addr_reg][7];
      end
      else if (state_reg == tws_pkg::ST_RD_DATA && bit_cnt_reg < tws_pkg::BIT_LAST)
      begin
        drive_low_reg <= ~tx_reg[6]; // RL7 RL1
      end
      else
      begin
        drive_low_reg <= 1'b0; // RL9
      end
    end
  end

  // outputs: open-drain, output value fixed low
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      sda_out <= 1'b0; // RL15
      sda_oe <= drive_low_reg && !line.start && !line.stop;
      busy <= (state_reg != tws_pkg::ST_IDLE);
    end
  end

endmodule : tws_slave

// *** testbench/tws_slave_props.sv ***
`timescale 1ns/1ps
// protocol checks on the slave ports
module tws_slave_props
#(
  parameter int REGS = tws_pkg::REG_COUNT
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic slave_addr_select_pins,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic busy,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_strobe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  logic seen_reg;
  logic [7:0] last_reg;
  // marks a write already made in this transfer
  always_ff @(posedge clk)
  begin
    if (srst || !busy)
      seen_reg <= 1'b0;
    else if (wr_strobe)
      seen_reg <= 1'b1;
  end
  // previous write target
  always_ff @(posedge clk)
  begin
    if (wr_strobe)
      last_reg <= wr_addr;
  end
  ////////////////////////////////////////
  a_pin_low_only: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  a_drive_clock_low: assert property ($rose(sda_oe) |-> !$past(scl_in, 3))
    else $error("data pulled while clock high");
  a_start_busy: assert property (scl_in && $past(scl_in, 2) && $fell(sda_in) |-> ##[1:6] busy)
    else $error("start not seen");
  a_stop_idle: assert property (scl_in && $past(scl_in, 2) && $rose(sda_in) |-> ##[1:8] !busy)
    else $error("stop not seen");
  a_idle_released: assert property (!busy |-> !sda_oe)
    else $error("data held while idle");
  a_strobe_pulse: assert property (wr_strobe |-> busy ##1 !wr_strobe)
    else $error("write strobe not a single pulse");
  a_addr_incr: assert property (wr_strobe && seen_reg |-> wr_addr == last_reg + 8'h01)
    else $error("write address not incremented");
  a_ack_holds: assert property ($rose(sda_oe) |=> sda_oe [*4])
    else $error("pull low too short");
  c_write: cover property (wr_strobe);
  c_pull: cover property ($rose(sda_oe));
  c_stop: cover property ($fell(busy));
endmodule : tws_slave_props

bind tws_slave tws_slave_props #(.REGS(REGS)) i_tws_slave_props (.clk, .srst, .scl_in,
  .sda_in, .slave_addr_select_pins, .sda_out, .sda_oe, .busy, .wr_addr, .wr_data, .wr_strobe);

// *** testbench/tws_master.sv ***
`timescale 1ns/1ps
// bus master model: drives the clock, only pulls data low
module tws_master
(
  input wire logic clk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_pull
);
  // idle bus
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  ////////////////////////////////////////
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : hold
  // start or repeated start
  task automatic start();
    sda_pull = 1'b0;
    hold(6);
    scl = 1'b1;
    hold(4);
    sda_pull = 1'b1;
    hold(4);
    scl = 1'b0;
    hold(1);
  endtask : start
  task automatic stop();
    sda_pull = 1'b1;
    hold(4);
    scl = 1'b1;
    hold(4);
    sda_pull = 1'b0;
    hold(4);
  endtask : stop
  // top n bits of bits, msb first; data changes only with clock low
  task automatic xfer(input logic [8:0] bits, input int n, output logic [8:0] r);
    r = 9'h1ff;
    for (int i = 8; i > 8 - n; i--)
    begin
      sda_pull = ~bits[i];
      hold(4);
      scl = 1'b1;
      hold(3);
      r[i] = sda_wire;
      scl = 1'b0;
      hold(1);
    end
  endtask : xfer
endmodule : tws_master

// *** testbench/tb.sv ***
`timescale 1ns/1ps
// bench: master model, open-drain wire, register slave
module tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic sel = 1'b0;
  logic scl, sda_pull, sda_wire, sda_out, sda_oe, busy, wr_strobe;
  logic [7:0] wr_addr, wr_data;
  logic [7:0] q_addr [$];
  logic [7:0] q_data [$];
  logic [7:0] vals [3] = '{8'ha1, 8'h5b, 8'hc8};
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;
  always #50 clk = ~clk;
  // pull-up unless a party pulls low
  assign sda_wire = (sda_pull || sda_oe) ? 1'b0 : 1'b1;
  tws_master i_tws_master (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_pull(sda_pull));
  tws_slave i_tws_slave (.clk(clk), .srst(srst), .scl_in(scl), .sda_in(sda_wire),
    .slave_addr_select_pins(sel), .sda_out(sda_out), .sda_oe(sda_oe), .busy(busy),
    .wr_addr(wr_addr), .wr_data(wr_data), .wr_strobe(wr_strobe));
  // write log and hang guard
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (wr_strobe === 1'b1)
    begin
      q_addr.push_back(wr_addr);
      q_data.push_back(wr_data);
    end
    if (cycles == 20000)
    begin
      n_mismatch = n_mismatch + 1;
      report_and_stop();
    end
  end
  ////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic send(input logic [7:0] d, input logic exp_ack);
    logic [8:0] r;
    i_tws_master.xfer({d, 1'b1}, 9, r);
    check("ack", {7'h00, r[0]}, {7'h00, exp_ack});
  endtask : send
  task automatic recv(input logic [7:0] exp, input logic mack);
    logic [8:0] r;
    i_tws_master.xfer({8'hff, mack}, 9, r);
    check("read data", r[8:1], exp);
  endtask : recv
  // three writes wrapping past the top address
  task automatic t_write();
    q_addr = {};
    q_data = {};
    i_tws_master.start();
    send(8'h98, 1'b0);
    send(8'hfe, 1'b0);
    for (int i = 0; i < 3; i++)
      send(vals[i], 1'b0);
    i_tws_master.stop();
    check("writes", 8'(q_addr.size()), 8'h03);
    for (int i = 0; i < 3; i++)
    begin
      check("wr_addr", q_addr[i], 8'(8'hfe + i));
      check("wr_data", q_data[i], vals[i]);
    end
    // the stop needs the sampler delay plus the output flop before busy drops
    i_tws_master.hold(2);
    check("busy", {7'h00, busy}, 8'h00);
    $display("write burst done");
  endtask : t_write
  // base set, repeated start, read back, master ends with no ack
  task automatic t_read();
    i_tws_master.start();
    send(8'h98, 1'b0);
    send(8'hfe, 1'b0);
    i_tws_master.start();
    send(8'h99, 1'b0);
    for (int i = 0; i < 3; i++)
      recv(vals[i], i == 2);
    i_tws_master.hold(6);
    check("release", {7'h00, sda_oe}, 8'h00);
    i_tws_master.stop();
    $display("read burst done");
  endtask : t_read
  // each select level against both addresses
  task automatic t_select();
    for (int s = 0; s < 2; s++)
    begin
      sel = s[0];
      for (int k = 0; k < 2; k++)
      begin
        i_tws_master.start();
        send({6'h26, k[0], 1'b0}, k[0] ^ s[0]);
        send(8'h00, k[0] ^ s[0]);
        i_tws_master.stop();
      end
    end
    sel = 1'b0;
    $display("address select done");
  endtask : t_select
  // start inside a data byte drops it
  task automatic t_abort();
    logic [8:0] r;
    q_addr = {};
    i_tws_master.start();
    send(8'h98, 1'b0);
    send(8'h10, 1'b0);
    i_tws_master.xfer(9'h1e1, 4, r);
    i_tws_master.start();
    send(8'h98, 1'b0);
    i_tws_master.stop();
    check("aborted writes", 8'(q_addr.size()), 8'h00);
    $display("abort done");
  endtask : t_abort
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  // reset, then the scenarios
  initial
  begin
    repeat (2) @(posedge clk);
    #1;
    srst = 1'b0;
    i_tws_master.hold(6);
    t_write();
    t_read();
    t_select();
    t_abort();
    report_and_stop();
  end
endmodule : tb
